// ---- design/bst_pkg.sv ----
package bst_pkg;

  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPD_IR
  } bst_state_t;

  // register widths
  localparam int BST_IR_W = 3;
  localparam int BST_IN_W = 8;
  localparam int BST_OUT_W = 8;
  localparam int BST_BSR_W = BST_IN_W + BST_OUT_W;
  localparam int BST_ID_W = 32;

  // instruction codes
  localparam logic [BST_IR_W-1:0] BST_OP_EXTEST = 3'h0;
  localparam logic [BST_IR_W-1:0] BST_OP_SAMPLE = 3'h1;
  localparam logic [BST_IR_W-1:0] BST_OP_IDCODE = 3'h2;
  localparam logic [BST_IR_W-1:0] BST_OP_BYPASS = 3'h7;

  // fixed capture pattern of the instruction shift register
  localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE = 3'h4;
  // identification word, value arbitrary, lsb set as a marker
  localparam logic [BST_ID_W-1:0] BST_IDCODE_VAL = 32'h5a5a_0001;

  // reset values
  localparam logic [BST_BSR_W-1:0] BST_BSR_RST = 16'h0000;
  localparam logic [BST_OUT_W-1:0] BST_PIN_RST = 8'h00;
  localparam int BST_RESET_TMS_CNT = 5;

endpackage

// ---- design/bst_tap_top.sv ----
`timescale 1ns/10ps
// Overview of operation
// - five consecutive tms-high tck rises reach test-logic-reset from any state
// - in test-logic-reset test logic is off and instruction becomes idcode
// - power-up enters test-logic-reset; it stays there while tms is high
// - run-test/idle holds on tms low, goes to select-dr on tms high
// - select-dr goes to capture-dr on tms low, select-ir on tms high
// - capture-dr loads pin samples into boundary register under extest or sample
// - capture-dr goes to exit1-dr on tms high, shift-dr on tms low
// - shift-dr shifts selected register toward tdo; exit1-dr on tms high
// - exit1-dr goes to update-dr on tms high, pause-dr on tms low
// - pause-dr holds data; stays on tms low, exit2-dr on tms high
// - exit2-dr goes to update-dr on tms high, shift-dr on tms low
// - boundary parallel output loads on falling tck in update-dr only
// - select-ir goes to capture-ir on tms low, test-logic-reset on tms high
// - capture-ir loads the fixed pattern 100 into instruction shift register
// - capture-ir goes to exit1-ir on tms high, shift-ir on tms low
// - shift-ir shifts instruction register toward tdo; exit1-ir on tms high
// - exit1-ir goes to update-ir on tms high, pause-ir on tms low
// - pause-ir halts shifting; stays on tms low, exit2-ir on tms high
// - exit2-ir goes to update-ir on tms high, shift-ir on tms low
// - update-ir latches shifted instruction on falling tck; it becomes current
// - current instruction changes only in update-ir and test-logic-reset; data registers hold outside capture-dr, shift-dr and update-dr
module bst_tap_top
  import bst_pkg::*;
(
  // system clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // tester link
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // device pins and core
  input wire logic [BST_IN_W-1:0] pin_in,
  input wire logic [BST_OUT_W-1:0] core_out_in,
  output logic [BST_OUT_W-1:0] pin_out_out,
  output logic test_mode_out
);

  typedef struct packed {
    bst_state_t state;
    logic [BST_IR_W-1:0] ir_sh;
    logic [BST_BSR_W-1:0] bsr_sh;
    logic [BST_ID_W-1:0] id_sh;
    logic byp;
    logic [BST_IN_W-1:0] pin_s1;
    logic [BST_IN_W-1:0] pin_s2;
    logic [BST_OUT_W-1:0] core_s1;
    logic [BST_OUT_W-1:0] core_s2;
  } bst_pos_t;

  typedef struct packed {
    logic [BST_IR_W-1:0] ir;
    logic [BST_BSR_W-1:0] bsr_upd;
    logic upd_tgl;
    logic extest;
    logic tdo;
    logic tdo_oe;
  } bst_neg_t;

  typedef struct packed {
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic ext_s1;
    logic ext_s2;
    logic [BST_OUT_W-1:0] bsr_word;
    logic [BST_OUT_W-1:0] pin_out;
    logic test_mode;
  } bst_sys_t;

  bst_pos_t pos_q, pos_d;
  bst_neg_t neg_q, neg_d;
  bst_sys_t sys_q, sys_d;
  logic [1:0] trst_q;
  logic tck_rstn;

  function automatic logic bsr_sel(input logic [BST_IR_W-1:0] op);
    bsr_sel = (op == BST_OP_EXTEST) || (op == BST_OP_SAMPLE);
  endfunction

  function automatic bst_state_t next_state(input bst_state_t s, input logic tms);
    case (s)
      ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
      default: next_state = ST_RESET;
    endcase
  endfunction

  // tck-side reset: asserts at once, releases on the second tck rise
  always_ff @(posedge tck_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trst_q <= 2'h0;
    end else begin
      trst_q <= {trst_q[0], 1'b1};
    end
  end
  assign tck_rstn = trst_q[1];

  // rising tck: controller and shift paths; tms/tdi are tck-synchronous
  always_comb begin
    pos_d = pos_q;
    pos_d.state = next_state(pos_q.state, tms_in);
    pos_d.pin_s1 = pin_in;
    pos_d.pin_s2 = pos_q.pin_s1;
    pos_d.core_s1 = core_out_in;
    pos_d.core_s2 = pos_q.core_s1;
    case (pos_q.state)
      ST_CAP_DR: begin
        if (bsr_sel(neg_q.ir)) begin
          pos_d.bsr_sh = {pos_q.core_s2, pos_q.pin_s2};
        end else if (neg_q.ir == BST_OP_IDCODE) begin
          pos_d.id_sh = BST_IDCODE_VAL;
        end else begin
          pos_d.byp = 1'b0;
        end
      end
      ST_SHIFT_DR: begin
        if (bsr_sel(neg_q.ir)) begin
          pos_d.bsr_sh = {tdi_in, pos_q.bsr_sh[BST_BSR_W-1:1]};
        end else if (neg_q.ir == BST_OP_IDCODE) begin
          pos_d.id_sh = {tdi_in, pos_q.id_sh[BST_ID_W-1:1]};
        end else begin
          pos_d.byp = tdi_in;
        end
      end
      ST_CAP_IR: pos_d.ir_sh = BST_IR_CAPTURE;
      ST_SHIFT_IR: pos_d.ir_sh = {tdi_in, pos_q.ir_sh[BST_IR_W-1:1]};
      default: begin
        // pause, exit, select and idle hold every shift register
        pos_d.byp = pos_q.byp;
      end
    endcase
  end

  always_ff @(posedge tck_in or negedge tck_rstn) begin
    if (!tck_rstn) begin
      pos_q <= '{state: ST_RESET, ir_sh: BST_IR_CAPTURE, bsr_sh: BST_BSR_RST,
                 id_sh: BST_IDCODE_VAL, byp: 1'b0, pin_s1: '0, pin_s2: '0,
                 core_s1: '0, core_s2: '0};
    end else begin
      pos_q <= pos_d;
    end
  end

  // falling tck: instruction, parallel boundary output, tdo
  always_comb begin
    neg_d = neg_q;
    if (pos_q.state == ST_RESET) begin
      neg_d.ir = BST_OP_IDCODE;
    end else if (pos_q.state == ST_UPD_IR) begin
      neg_d.ir = pos_q.ir_sh;
    end
    if (pos_q.state == ST_UPD_DR && bsr_sel(neg_q.ir)) begin
      neg_d.bsr_upd = pos_q.bsr_sh;
      neg_d.upd_tgl = ~neg_q.upd_tgl;
    end
    neg_d.extest = (neg_d.ir == BST_OP_EXTEST) && (pos_q.state != ST_RESET);
    neg_d.tdo_oe = (pos_q.state == ST_SHIFT_DR) || (pos_q.state == ST_SHIFT_IR);
    if (pos_q.state == ST_SHIFT_IR) begin
      neg_d.tdo = pos_q.ir_sh[0];
    end else if (pos_q.state != ST_SHIFT_DR) begin
      neg_d.tdo = 1'b0;
    end else if (bsr_sel(neg_q.ir)) begin
      neg_d.tdo = pos_q.bsr_sh[0];
    end else if (neg_q.ir == BST_OP_IDCODE) begin
      neg_d.tdo = pos_q.id_sh[0];
    end else begin
      neg_d.tdo = pos_q.byp;
    end
  end

  always_ff @(negedge tck_in or negedge tck_rstn) begin
    if (!tck_rstn) begin
      neg_q <= '{ir: BST_OP_IDCODE, bsr_upd: BST_BSR_RST, upd_tgl: 1'b0,
                 extest: 1'b0, tdo: 1'b0, tdo_oe: 1'b0};
    end else begin
      neg_q <= neg_d;
    end
  end

  // system side: toggle handshake for the update word, two flops for extest
  always_comb begin
    sys_d = sys_q;
    sys_d.tgl_s1 = neg_q.upd_tgl;
    sys_d.tgl_s2 = sys_q.tgl_s1;
    sys_d.tgl_s3 = sys_q.tgl_s2;
    sys_d.ext_s1 = neg_q.extest;
    sys_d.ext_s2 = sys_q.ext_s1;
    if (sys_q.tgl_s2 != sys_q.tgl_s3) begin
      sys_d.bsr_word = neg_q.bsr_upd[BST_BSR_W-1:BST_IN_W];
    end
    sys_d.pin_out = sys_q.ext_s2 ? sys_q.bsr_word : core_out_in;
    sys_d.test_mode = sys_q.ext_s2;
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sys_q <= '{tgl_s1: 1'b0, tgl_s2: 1'b0, tgl_s3: 1'b0, ext_s1: 1'b0,
                 ext_s2: 1'b0, bsr_word: BST_PIN_RST, pin_out: BST_PIN_RST,
                 test_mode: 1'b0};
    end else begin
      sys_q <= sys_d;
    end
  end

  assign tdo_out = neg_q.tdo;
  assign tdo_oe_out = neg_q.tdo_oe;
  assign pin_out_out = sys_q.pin_out;
  assign test_mode_out = sys_q.test_mode;

  // helper: consecutive tms-high count, saturating
  logic [2:0] tms_cnt_q;
  always_ff @(posedge tck_in or negedge tck_rstn) begin
    if (!tck_rstn) begin
      tms_cnt_q <= 3'h0;
    end else if (!tms_in) begin
      tms_cnt_q <= 3'h0;
    end else if (tms_cnt_q != 3'h7) begin
      tms_cnt_q <= tms_cnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge tck_in);
  endclocking
  default disable iff (!tck_rstn);

  a_five_ones_reset: assert property (tms_cnt_q >= 3'h5 |-> pos_q.state == ST_RESET)
    else $error("five tms highs did not reach reset");
  a_reset_idcode: assert property ($past(pos_q.state) == ST_RESET |-> neg_q.ir == BST_OP_IDCODE
                                   && !neg_q.extest)
    else $error("reset state left instruction not idcode");
  a_reset_holds: assert property (pos_q.state == ST_RESET && tms_in |=> pos_q.state == ST_RESET)
    else $error("reset state left with tms high");
  a_idle_moves: assert property (pos_q.state == ST_IDLE |=>
                                 pos_q.state == ($past(tms_in) ? ST_SEL_DR : ST_IDLE))
    else $error("idle transition wrong");
  a_sel_dr_branch: assert property (pos_q.state == ST_SEL_DR |=>
                                    pos_q.state == ($past(tms_in) ? ST_SEL_IR : ST_CAP_DR))
    else $error("select-dr transition wrong");
  a_cap_dr_pins: assert property (pos_q.state == ST_CAP_DR && bsr_sel(neg_q.ir) |=>
                                  pos_q.bsr_sh == $past({pos_q.core_s2, pos_q.pin_s2}))
    else $error("boundary capture wrong");
  a_shift_dr_path: assert property (pos_q.state == ST_SHIFT_DR && bsr_sel(neg_q.ir) |=>
                                    pos_q.bsr_sh[BST_BSR_W-2:0] == $past(pos_q.bsr_sh[BST_BSR_W-1:1]))
    else $error("boundary shift wrong");
  a_exit_pause_dr: assert property (pos_q.state == ST_EXIT1_DR && !tms_in ##1
                                    pos_q.state == ST_PAUSE_DR && !tms_in |=>
                                    pos_q.state == ST_PAUSE_DR && $stable(pos_q.bsr_sh))
    else $error("pause-dr entry or hold wrong");
  // the fall inside a cycle acts on the state sampled at its closing rise
  a_upd_bsr_only: assert property (pos_q.state != ST_UPD_DR |->
                                   neg_q.bsr_upd == $past(neg_q.bsr_upd))
    else $error("parallel output changed outside update-dr");
  a_cap_ir_fixed: assert property (pos_q.state == ST_CAP_IR |=> pos_q.ir_sh == 3'h4)
    else $error("capture-ir pattern wrong");
  a_shift_ir_path: assert property (pos_q.state == ST_SHIFT_IR |=>
                                    pos_q.ir_sh == {$past(tdi_in), $past(pos_q.ir_sh[2:1])})
    else $error("instruction shift wrong");
  a_ir_stable: assert property (pos_q.state != ST_UPD_IR && pos_q.state != ST_RESET
                                |-> neg_q.ir == $past(neg_q.ir))
    else $error("instruction changed outside update-ir");
  a_upd_ir_load: assert property (pos_q.state == ST_UPD_IR |=> neg_q.ir == $past(pos_q.ir_sh))
    else $error("update-ir did not latch instruction");
  a_reset_leaves: assert property (pos_q.state == ST_RESET |=>
                                   pos_q.state == ($past(tms_in) ? ST_RESET : ST_IDLE))
    else $error("reset state exit wrong");
  a_cap_dr_branch: assert property (pos_q.state == ST_CAP_DR |=>
                                    pos_q.state == ($past(tms_in) ? ST_EXIT1_DR : ST_SHIFT_DR))
    else $error("capture-dr transition wrong");
  a_shift_dr_branch: assert property (pos_q.state == ST_SHIFT_DR |=>
                                      pos_q.state == ($past(tms_in) ? ST_EXIT1_DR : ST_SHIFT_DR))
    else $error("shift-dr transition wrong");
  a_exit1_dr_branch: assert property (pos_q.state == ST_EXIT1_DR |=>
                                      pos_q.state == ($past(tms_in) ? ST_UPD_DR : ST_PAUSE_DR))
    else $error("exit1-dr transition wrong");
  a_pause_dr_branch: assert property (pos_q.state == ST_PAUSE_DR |=>
                                      pos_q.state == ($past(tms_in) ? ST_EXIT2_DR : ST_PAUSE_DR))
    else $error("pause-dr transition wrong");
  a_exit2_dr_branch: assert property (pos_q.state == ST_EXIT2_DR |=>
                                      pos_q.state == ($past(tms_in) ? ST_UPD_DR : ST_SHIFT_DR))
    else $error("exit2-dr transition wrong");
  a_upd_dr_next: assert property (pos_q.state == ST_UPD_DR |=>
                                  pos_q.state == ($past(tms_in) ? ST_SEL_DR : ST_IDLE))
    else $error("update-dr transition wrong");
  a_sel_ir_branch: assert property (pos_q.state == ST_SEL_IR |=>
                                    pos_q.state == ($past(tms_in) ? ST_RESET : ST_CAP_IR))
    else $error("select-ir transition wrong");
  a_cap_ir_branch: assert property (pos_q.state == ST_CAP_IR |=>
                                    pos_q.state == ($past(tms_in) ? ST_EXIT1_IR : ST_SHIFT_IR))
    else $error("capture-ir transition wrong");
  a_shift_ir_branch: assert property (pos_q.state == ST_SHIFT_IR |=>
                                      pos_q.state == ($past(tms_in) ? ST_EXIT1_IR : ST_SHIFT_IR))
    else $error("shift-ir transition wrong");
  a_exit1_ir_branch: assert property (pos_q.state == ST_EXIT1_IR |=>
                                      pos_q.state == ($past(tms_in) ? ST_UPD_IR : ST_PAUSE_IR))
    else $error("exit1-ir transition wrong");
  a_pause_ir_branch: assert property (pos_q.state == ST_PAUSE_IR |=>
                                      pos_q.state == ($past(tms_in) ? ST_EXIT2_IR : ST_PAUSE_IR))
    else $error("pause-ir transition wrong");
  a_pause_ir_hold: assert property (pos_q.state == ST_PAUSE_IR |=> $stable(pos_q.ir_sh))
    else $error("instruction shift moved in pause-ir");
  a_exit2_ir_branch: assert property (pos_q.state == ST_EXIT2_IR |=>
                                      pos_q.state == ($past(tms_in) ? ST_UPD_IR : ST_SHIFT_IR))
    else $error("exit2-ir transition wrong");
  a_upd_ir_next: assert property (pos_q.state == ST_UPD_IR |=>
                                  pos_q.state == ($past(tms_in) ? ST_SEL_DR : ST_IDLE))
    else $error("update-ir transition wrong");
  a_idle_keeps_bsr: assert property (pos_q.state == ST_IDLE |=> $stable(pos_q.bsr_sh))
    else $error("boundary register moved in idle");
  a_oe_in_shift: assert property (neg_q.tdo_oe == (pos_q.state == ST_SHIFT_DR ||
                                                   pos_q.state == ST_SHIFT_IR))
    else $error("tdo enable outside shift states");
  // pin side runs on the system clock
  a_pins_normal: assert property (@(posedge mclk_in) disable iff (!rstn_in)
                                  !sys_q.ext_s2 |=> pin_out_out == $past(core_out_in))
    else $error("pins did not follow core in normal mode");

  c_ir_update: cover property (pos_q.state == ST_UPD_IR);
  c_extest_update: cover property (pos_q.state == ST_UPD_DR && neg_q.ir == BST_OP_EXTEST);
  c_reset_from_shift: cover property (pos_q.state == ST_SHIFT_DR ##5 pos_q.state == ST_RESET);
  c_pause_ir: cover property (pos_q.state == ST_PAUSE_IR ##1 pos_q.state == ST_EXIT2_IR);
  c_bypass_shift: cover property (pos_q.state == ST_SHIFT_DR && neg_q.ir == BST_OP_BYPASS);

endmodule

// ---- sim/boundary_scan_tap_controller_bench.sv ----
`timescale 1ns/10ps
module boundary_scan_tap_controller_bench;
  import bst_pkg::*;
  logic mclk_in, rstn_in, tck, tms, tdi, tdo_out, tdo_oe_out, test_mode_out;
  logic [BST_IN_W-1:0] pin_in;
  logic [BST_OUT_W-1:0] core_out_in, pin_out_out;
  logic [31:0] rd;
  int err_count, cmp_count;

`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  bst_tap_top uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .pin_in(pin_in),
    .core_out_in(core_out_in), .pin_out_out(pin_out_out), .test_mode_out(test_mode_out));
  bst_tester tester (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_out),
    .tdo_oe_in(tdo_oe_out));

  // tms walk, lsb first
  task automatic nav(input logic [7:0] seq, input int n);
    logic t;
    for (int i = 0; i < n; i++) tester.pulse(seq[i], 1'b0, 1'b0, t);
  endtask

  // n bits in a shift state, leaving to exit1 on the last
  task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
    logic t;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tester.pulse(i == n - 1, 1'b1, din[i], t);
      dout[i] = t;
    end
  endtask

  // ir load with a pause after two bits
  task automatic load_ir(input logic [BST_IR_W-1:0] op);
    logic [31:0] b;
    nav(8'h03, 4);
    shift({29'h0, op}, 2, rd);
    nav(8'h04, 4);
    shift({31'h0, op[2]}, 1, b);
    rd[2] = b[0];
    `CHK("ir capture", BST_IR_CAPTURE, rd[2:0])
    nav(8'h01, 2);
  endtask

  task automatic read_id();
    nav(8'h01, 3);
    shift(32'h0, 32, rd);
    `CHK("idcode", BST_IDCODE_VAL, rd)
    nav(8'h01, 2);
    `CHK("oe idle", 1'b0, tdo_oe_out)
  endtask

  task automatic t_idcode();
    nav(8'h00, 3);
    read_id();
  endtask

  task automatic t_bypass();
    logic [31:0] a, b;
    load_ir(BST_OP_BYPASS);
    nav(8'h01, 3);
    shift(32'hb, 2, a);
    nav(8'h04, 4);
    shift(32'h2, 2, b);
    `CHK("bypass path", 3'h3, {b[1:0], a[1]})
    nav(8'h01, 2);
    repeat (6) @(negedge mclk_in);
    `CHK("bypass mode", 1'b0, test_mode_out)
  endtask

  task automatic t_extest();
    load_ir(BST_OP_EXTEST);
    repeat (6) @(negedge mclk_in);
    `CHK("extest mode", 1'b1, test_mode_out)
    nav(8'h01, 3);
    shift(32'h9600, 16, rd);
    `CHK("pin capture", 8'hc3, rd[7:0])
    `CHK("pins held", 8'h00, pin_out_out)
    nav(8'h01, 2);
    repeat (6) @(negedge mclk_in);
    `CHK("pins updated", 8'h96, pin_out_out)
  endtask

  task automatic t_resets();
    nav(8'h07, 3);
    repeat (6) @(negedge mclk_in);
    `CHK("sel ir reset", 1'b0, test_mode_out)
    `CHK("pins normal", 8'h5a, pin_out_out)
    nav(8'h00, 1);
    load_ir(BST_OP_EXTEST);
    nav(8'h01, 3);
    nav(8'h1f, 5);
    repeat (6) @(negedge mclk_in);
    `CHK("tms reset", 1'b0, test_mode_out)
    nav(8'h00, 1);
    read_id();
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    summarize();
  end

  initial begin
    err_count = 0;
    cmp_count = 0;
    rstn_in = 1'b0;
    pin_in = 8'hc3;
    core_out_in = 8'h5a;
    repeat (3) @(negedge mclk_in);
    rstn_in = 1'b1;
    nav(8'h07, 3);
    `CHK("oe reset", 1'b0, tdo_oe_out)
    t_idcode();
    t_bypass();
    t_extest();
    t_resets();
    summarize();
  end
endmodule

// ---- sim/bst_tester.sv ----
`timescale 1ns/10ps
module bst_tester (
  // link to the device
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end

  // one 30 ns tck cycle; tck stands low between calls
  task automatic pulse(input logic tms, input logic sh, input logic tdi, output logic tdo);
    #1;
    tms_out = tms;
    // tdi not wanted outside shifts, so it toggles
    tdi_out = sh ? tdi : ~tdi_out;
    #14;
    tdo = tdo_oe_in ? tdo_in : 1'bz;
    tck_out = 1'b1;
    #15;
    tck_out = 1'b0;
  endtask
endmodule
